/* File: design/time_link_pkg.sv */
// Shared constants and types for the serial time-of-day link.
// Assumes both ends run their system logic on a 200 MHz clock.
package time_link_pkg;

   // =====================================================================
   // Rates, cycle counts and sizes
   // =====================================================================
   localparam int SYS_CLK_HZ = 200_000_000;
   localparam int BIT_CLK_HZ = 10_000_000;
   localparam int HEARTBEAT_HZ = 4_000;
   localparam int REF_CLK_HZ = 25_000_000;

   // System cycles per half bit-clock period
   localparam int BIT_HALF_CYCLES = SYS_CLK_HZ / (2 * BIT_CLK_HZ);
   // Bit-clock periods between heartbeats
   localparam int FRAME_BITS = BIT_CLK_HZ / HEARTBEAT_HZ;
   // System cycles per half reference-clock period
   localparam int REF_HALF_CYCLES = SYS_CLK_HZ / (2 * REF_CLK_HZ);

   localparam int TIME_WIDTH = 32;
   localparam int FIFO_DEPTH = 4;
   localparam logic PIN_RESET = 1'b0;
   localparam logic LOCK_RESET = 1'b0;

   // =====================================================================
   // Link modes
   // =====================================================================
   typedef enum logic [2:0] {
      MODE_OFF = 3'b001,
      MODE_SERIAL = 3'b010,
      MODE_PACKET = 3'b100
   } link_mode_t;

endpackage : time_link_pkg

/* File: design/time_link_if.sv */
// Pins between the documented timing device and its peer node.
// Assumes undriven pins are pulled low; no clocking block is used.
`timescale 1ns/1ps
interface time_link_if;

   // =====================================================================
   // Drivers of each end
   // =====================================================================
   logic dev_bit_clock_out, dev_bit_clock_oe, peer_bit_clock_out, peer_bit_clock_oe;
   logic dev_heartbeat_out, dev_heartbeat_oe, peer_heartbeat_out, peer_heartbeat_oe;
   logic dev_value_out, dev_value_oe, peer_value_out, peer_value_oe;
   logic spare_bit_clock_out, spare_bit_clock_oe;
   logic spare_heartbeat_out, spare_heartbeat_oe;
   logic spare_serial_value_out, spare_serial_value_oe;
   logic stamp_pll_locked, sync_pll_locked;
   logic timing_pll_reference_clock;

   // Pull-down wins when nobody drives
   logic time_link_bit_clock, time_link_heartbeat, time_link_serial_value;
   logic spare_bit_clock, spare_heartbeat, spare_serial_value;
   assign time_link_bit_clock = dev_bit_clock_oe ? dev_bit_clock_out :
                                (peer_bit_clock_oe ? peer_bit_clock_out : 1'b0);
   assign time_link_heartbeat = dev_heartbeat_oe ? dev_heartbeat_out :
                                (peer_heartbeat_oe ? peer_heartbeat_out : 1'b0);
   assign time_link_serial_value = dev_value_oe ? dev_value_out :
                                   (peer_value_oe ? peer_value_out : 1'b0);
   assign spare_bit_clock = spare_bit_clock_oe & spare_bit_clock_out;
   assign spare_heartbeat = spare_heartbeat_oe & spare_heartbeat_out;
   assign spare_serial_value = spare_serial_value_oe & spare_serial_value_out;

   // =====================================================================
   // Views
   // =====================================================================
   modport device_end (
      output dev_bit_clock_out, dev_bit_clock_oe, dev_heartbeat_out, dev_heartbeat_oe,
      output dev_value_out, dev_value_oe,
      output spare_bit_clock_out, spare_bit_clock_oe, spare_heartbeat_out, spare_heartbeat_oe,
      output spare_serial_value_out, spare_serial_value_oe,
      output stamp_pll_locked, sync_pll_locked,
      input time_link_bit_clock, time_link_heartbeat, time_link_serial_value,
      input spare_heartbeat, timing_pll_reference_clock
   );
   modport peer_end (
      output peer_bit_clock_out, peer_bit_clock_oe, peer_heartbeat_out, peer_heartbeat_oe,
      output peer_value_out, peer_value_oe, timing_pll_reference_clock,
      input time_link_bit_clock, time_link_heartbeat, time_link_serial_value,
      input stamp_pll_locked, sync_pll_locked
   );

endinterface : time_link_if

/* File: design/time_link_device.sv */
// Device end of the serial time-of-day link, plus the shared FIFO and
// serial engine that the peer end also uses.
// Assumes I_CLK at 200 MHz and a peer that keeps its side of the link.
`timescale 1ns/1ps

// =========================================================================
// Stream FIFO
// =========================================================================
module stream_fifo #(
   parameter int WIDTH = time_link_pkg::TIME_WIDTH,
   parameter int DEPTH = time_link_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Fill side
   input wire logic [WIDTH-1:0] i_data,
   input wire logic i_valid,
   output logic o_ready,
   // Drain side
   output logic [WIDTH-1:0] o_data,
   output logic o_valid,
   input wire logic i_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr;
   logic [AW:0] count;
   wire push = i_valid & o_ready;
   wire pop = o_valid & i_ready;

   // Flags straight from the occupancy count
   assign o_ready = count != (AW+1)'(DEPTH);
   assign o_valid = count != '0;
   assign o_data = mem[rd_ptr];

   // Storage written only on an accepted word
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr] <= i_data;
      end
   end

   // Pointers wrap explicitly so DEPTH need not be a power of two
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         if (push & ~pop) count <= count + 1'b1;
         else if (pop & ~push) count <= count - 1'b1;
      end
   end
endmodule : stream_fifo

// =========================================================================
// Serial time engine: transmitter on I_CLK, receiver on the link clock
// =========================================================================
module time_link_engine #(
   parameter int WIDTH = time_link_pkg::TIME_WIDTH,
   parameter int DEPTH = time_link_pkg::FIFO_DEPTH,
   parameter int HALF = time_link_pkg::BIT_HALF_CYCLES,
   parameter int FRAME = time_link_pkg::FRAME_BITS
) (
   // System clock domain
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_tx_on,
   input wire logic i_rx_on,
   // Link clock domain
   input wire logic i_link_clk,
   input wire logic i_heartbeat,
   input wire logic i_value,
   // Transmit stream
   input wire logic [WIDTH-1:0] i_tx_data,
   input wire logic i_tx_valid,
   output logic o_tx_ready,
   // Receive stream
   output logic [WIDTH-1:0] o_rx_data,
   output logic o_rx_valid,
   input wire logic i_rx_ready,
   output logic o_rx_dropped,
   // Pin drive values
   output logic o_bit_clk,
   output logic o_heartbeat,
   output logic o_value
);
   localparam int HW = (HALF > 1) ? $clog2(HALF) : 1;
   localparam int FW = $clog2(FRAME);
   localparam int CW = $clog2(WIDTH + 1);

   logic [HW-1:0] half_cnt;
   logic [FW-1:0] bit_idx;
   logic rise_d;
   logic [WIDTH-1:0] shift_out, last_word, fifo_data;
   logic fifo_valid;
   wire half_end = half_cnt == HW'(HALF - 1);
   wire rise = half_end & ~o_bit_clk;
   wire frame_load = rise_d & (bit_idx == FW'(FRAME - 1));
   wire fifo_pop = frame_load & fifo_valid & i_tx_on;
   wire [WIDTH-1:0] load_word = (fifo_valid & i_tx_on) ? fifo_data : last_word;

   // Words wait here until the next heartbeat; a full FIFO stalls the user
   stream_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) tx_fifo (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_data(i_tx_data),
      .i_valid(i_tx_valid),
      .o_ready(o_tx_ready),
      .o_data(fifo_data),
      .o_valid(fifo_valid),
      .i_ready(fifo_pop)
   );

   // Bit clock from a divider of I_CLK
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         half_cnt <= '0;
         o_bit_clk <= time_link_pkg::PIN_RESET;
         rise_d <= 1'b0;
      end else begin
         half_cnt <= half_end ? '0 : half_cnt + 1'b1;
         if (half_end) o_bit_clk <= ~o_bit_clk;
         rise_d <= rise;
      end
   end

   // Data moves one system cycle after the rising edge so the far side
   // samples a settled value at its next rising edge
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         bit_idx <= FW'(FRAME - 1);
         o_heartbeat <= time_link_pkg::PIN_RESET;
         o_value <= time_link_pkg::PIN_RESET;
         shift_out <= '0;
         last_word <= '0;
      end else if (rise_d) begin
         bit_idx <= (bit_idx == FW'(FRAME - 1)) ? '0 : bit_idx + 1'b1;
         o_heartbeat <= frame_load;
         if (frame_load) begin
            last_word <= load_word;
            shift_out <= {load_word[WIDTH-2:0], 1'b0};
            o_value <= load_word[WIDTH-1] & i_tx_on;
         end else begin
            shift_out <= {shift_out[WIDTH-2:0], 1'b0};
            o_value <= shift_out[WIDTH-1] & i_tx_on;
         end
      end
   end

   // Receiver: reset and enable brought into the link domain
   logic rst_meta, rst_link, on_meta, on_link;
   logic [CW-1:0] rx_cnt;
   logic [WIDTH-1:0] rx_shift, rx_word;
   logic rx_done;
   always_ff @(posedge i_link_clk) begin
      rst_meta <= i_rst;
      rst_link <= rst_meta;
      on_meta <= i_rx_on;
      on_link <= on_meta;
   end

   // Heartbeat restarts the count; the last bit publishes the word. The link
   // clock is still during reset, so the done level is cleared by each heartbeat
   always_ff @(posedge i_link_clk) begin
      if (rst_link) begin
         rx_cnt <= '0;
         rx_shift <= '0;
         rx_word <= '0;
         rx_done <= 1'b0;
      end else if (on_link & i_heartbeat) begin
         rx_shift <= {{(WIDTH-1){1'b0}}, i_value};
         rx_cnt <= CW'(1);
         rx_done <= 1'b0;
      end else if (rx_cnt != '0) begin
         rx_shift <= {rx_shift[WIDTH-2:0], i_value};
         if (rx_cnt == CW'(WIDTH - 1)) begin
            rx_cnt <= '0;
            rx_word <= {rx_shift[WIDTH-2:0], i_value};
            rx_done <= 1'b1;
         end else begin
            rx_cnt <= rx_cnt + 1'b1;
         end
      end
   end

   // Level crossing; rx_word stays still while the done level is high
   logic tgl_meta, tgl_sync, tgl_seen;
   wire rx_new = tgl_sync & ~tgl_seen;
   wire rx_take = rx_new & (~o_rx_valid | i_rx_ready);
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         tgl_meta <= 1'b0;
         tgl_sync <= 1'b0;
         tgl_seen <= 1'b0;
         o_rx_valid <= 1'b0;
         o_rx_data <= '0;
         o_rx_dropped <= 1'b0;
      end else begin
         tgl_meta <= rx_done;
         tgl_sync <= tgl_meta;
         tgl_seen <= tgl_sync;
         o_rx_dropped <= rx_new & ~rx_take;
         if (rx_take) begin
            o_rx_data <= rx_word;
            o_rx_valid <= 1'b1;
         end else if (i_rx_ready) begin
            o_rx_valid <= 1'b0;
         end
      end
   end
endmodule : time_link_engine

// =========================================================================
// Device end
// =========================================================================
module time_link_device #(
   parameter int FRAME = time_link_pkg::FRAME_BITS
) (
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   // Link pins
   time_link_if.device_end link,
   // Configuration
   input wire time_link_pkg::link_mode_t I_LINK_MODE,
   input wire logic I_TRANSMITTER,
   input wire logic [1:0] I_PACKET_CLK_OUT_EN,
   input wire logic [1:0] I_PACKET_HB_OUT_EN,
   // PLL interface
   input wire logic I_STAMP_PLL_ENABLE,
   input wire logic I_SYNC_PLL_ENABLE,
   input wire logic I_STAMP_PLL_LOCK_RAW,
   input wire logic I_SYNC_PLL_LOCK_RAW,
   output logic O_PLL_REFERENCE_CLOCK,
   // Transmit stream
   input wire logic [time_link_pkg::TIME_WIDTH-1:0] I_TX_TIME,
   input wire logic I_TX_VALID,
   output logic O_TX_READY,
   // Receive stream
   output logic [time_link_pkg::TIME_WIDTH-1:0] O_RX_TIME,
   output logic O_RX_VALID,
   input wire logic I_RX_READY,
   output logic O_RX_DROPPED,
   // Packet-mode heartbeat inputs
   output logic [1:0] O_HEARTBEAT_SEEN
);
   logic eng_clk, eng_hb, eng_value;

   // Mode decode
   wire serial = I_LINK_MODE == time_link_pkg::MODE_SERIAL;
   wire packet = I_LINK_MODE == time_link_pkg::MODE_PACKET;
   wire serial_tx = serial & I_TRANSMITTER;
   wire serial_rx = serial & ~I_TRANSMITTER;

   time_link_engine #(.FRAME(FRAME)) engine (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_tx_on(serial_tx),
      .i_rx_on(serial_rx),
      .i_link_clk(link.time_link_bit_clock),
      .i_heartbeat(link.time_link_heartbeat),
      .i_value(link.time_link_serial_value),
      .i_tx_data(I_TX_TIME),
      .i_tx_valid(I_TX_VALID),
      .o_tx_ready(O_TX_READY),
      .o_rx_data(O_RX_TIME),
      .o_rx_valid(O_RX_VALID),
      .i_rx_ready(I_RX_READY),
      .o_rx_dropped(O_RX_DROPPED),
      .o_bit_clk(eng_clk),
      .o_heartbeat(eng_hb),
      .o_value(eng_value)
   );

   // Pin drivers; spare pins only ever drive in packet mode
   assign link.dev_bit_clock_out = eng_clk;
   assign link.dev_bit_clock_oe = serial_tx | (packet & I_PACKET_CLK_OUT_EN[0]);
   assign link.spare_bit_clock_out = eng_clk;
   assign link.spare_bit_clock_oe = packet & I_PACKET_CLK_OUT_EN[1];
   assign link.dev_heartbeat_out = eng_hb;
   assign link.dev_heartbeat_oe = serial_tx | (packet & I_PACKET_HB_OUT_EN[0]);
   assign link.spare_heartbeat_out = eng_hb;
   assign link.spare_heartbeat_oe = packet & I_PACKET_HB_OUT_EN[1];
   assign link.dev_value_out = eng_value;
   assign link.dev_value_oe = serial_tx;
   assign link.spare_serial_value_out = 1'b0;
   assign link.spare_serial_value_oe = 1'b0;
   assign O_PLL_REFERENCE_CLOCK = link.timing_pll_reference_clock;

   // Lock levels come from the analog PLLs, so they are synchronised first
   logic [1:0] lock_meta, lock_sync, stamp_sync_lock;
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         lock_meta <= '0;
         lock_sync <= '0;
         stamp_sync_lock <= {time_link_pkg::LOCK_RESET, time_link_pkg::LOCK_RESET};
      end else begin
         lock_meta <= {I_SYNC_PLL_LOCK_RAW, I_STAMP_PLL_LOCK_RAW};
         lock_sync <= lock_meta;
         stamp_sync_lock <= lock_sync & {I_SYNC_PLL_ENABLE, I_STAMP_PLL_ENABLE};
      end
   end
   assign link.stamp_pll_locked = stamp_sync_lock[0];
   assign link.sync_pll_locked = stamp_sync_lock[1];

   // Packet-mode heartbeat inputs: rising edge after two-flop capture
   logic [1:0] hb_meta, hb_sync, hb_last;
   wire [1:0] hb_listen = {2{packet}} & ~I_PACKET_HB_OUT_EN;
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         hb_meta <= '0;
         hb_sync <= '0;
         hb_last <= '0;
         O_HEARTBEAT_SEEN <= '0;
      end else begin
         hb_meta <= {link.spare_heartbeat, link.time_link_heartbeat};
         hb_sync <= hb_meta;
         hb_last <= hb_sync;
         O_HEARTBEAT_SEEN <= hb_sync & ~hb_last & hb_listen;
      end
   end
endmodule : time_link_device

/* File: design/time_link_peer.sv */
// Peer timing node: transmits or receives serial time and supplies
// the PLL reference clock.
// Assumes time_link_device.sv (FIFO and engine) is compiled first.
`timescale 1ns/1ps
module time_link_peer #(
   parameter int FRAME = time_link_pkg::FRAME_BITS
) (
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   // Link pins
   time_link_if.peer_end link,
   // Configuration
   input wire logic I_TRANSMITTER,
   input wire logic I_PLL_ENABLED,
   // Transmit stream
   input wire logic [time_link_pkg::TIME_WIDTH-1:0] I_TX_TIME,
   input wire logic I_TX_VALID,
   output logic O_TX_READY,
   // Receive stream
   output logic [time_link_pkg::TIME_WIDTH-1:0] O_RX_TIME,
   output logic O_RX_VALID,
   input wire logic I_RX_READY,
   output logic O_RX_DROPPED,
   // Qualified lock status
   output logic O_STAMP_PLL_LOCKED,
   output logic O_SYNC_PLL_LOCKED
);
   localparam int RW = $clog2(time_link_pkg::REF_HALF_CYCLES);
   logic eng_clk, eng_hb, eng_value;

   // =====================================================================
   // Serial engine, role opposite to the device's
   // =====================================================================
   time_link_engine #(.FRAME(FRAME)) engine (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_tx_on(I_TRANSMITTER),
      .i_rx_on(~I_TRANSMITTER),
      .i_link_clk(link.time_link_bit_clock),
      .i_heartbeat(link.time_link_heartbeat),
      .i_value(link.time_link_serial_value),
      .i_tx_data(I_TX_TIME),
      .i_tx_valid(I_TX_VALID),
      .o_tx_ready(O_TX_READY),
      .o_rx_data(O_RX_TIME),
      .o_rx_valid(O_RX_VALID),
      .i_rx_ready(I_RX_READY),
      .o_rx_dropped(O_RX_DROPPED),
      .o_bit_clk(eng_clk),
      .o_heartbeat(eng_hb),
      .o_value(eng_value)
   );

   // Link pins are driven only in the transmitter role
   assign link.peer_bit_clock_out = eng_clk;
   assign link.peer_bit_clock_oe = I_TRANSMITTER;
   assign link.peer_heartbeat_out = eng_hb;
   assign link.peer_heartbeat_oe = I_TRANSMITTER;
   assign link.peer_value_out = eng_value;
   assign link.peer_value_oe = I_TRANSMITTER;

   // =====================================================================
   // Reference clock divider
   // =====================================================================
   logic [RW-1:0] ref_cnt;
   logic ref_clk;
   wire ref_end = ref_cnt == RW'(time_link_pkg::REF_HALF_CYCLES - 1);
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         ref_cnt <= '0;
         ref_clk <= 1'b0;
      end else begin
         ref_cnt <= ref_end ? '0 : ref_cnt + 1'b1;
         if (ref_end) ref_clk <= ~ref_clk;
      end
   end
   assign link.timing_pll_reference_clock = ref_clk;

   // Level ignored until software reports the PLLs are set up
   logic [1:0] lock_meta, lock_sync;
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         lock_meta <= '0;
         lock_sync <= '0;
      end else begin
         lock_meta <= {link.sync_pll_locked, link.stamp_pll_locked};
         lock_sync <= lock_meta;
      end
   end
   assign O_STAMP_PLL_LOCKED = lock_sync[0] & I_PLL_ENABLED;
   assign O_SYNC_PLL_LOCKED = lock_sync[1] & I_PLL_ENABLED;
endmodule : time_link_peer

/* File: verification/time_link_checker.sv */
// Pin-level checks on the serial time link between the two ends.
// Assumes both ends and the pins are watched on the 200 MHz system clock.
`timescale 1ns/1ps
module time_link_checker #(
   parameter int FRAME = 40
) (
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   // Pin drivers and resolved levels
   input wire logic dev_bit_clock_oe,
   input wire logic peer_bit_clock_oe,
   input wire logic spare_serial_value_oe,
   input wire logic time_link_bit_clock,
   input wire logic time_link_heartbeat,
   input wire logic time_link_serial_value
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_SYS_RST);
   // =====================================================================
   // Frame timer
   // =====================================================================
   // Cycles since the last heartbeat rise; the first frame after reset is not timed
   int gap;
   logic hb_q, armed;
   always_ff @(posedge I_CLK) begin
      hb_q <= time_link_heartbeat;
      gap <= (time_link_heartbeat && !hb_q) ? 1 : gap + 1;
      armed <= I_SYS_RST ? 1'b0 : (armed | (time_link_heartbeat & !hb_q));
   end
   // Phases of the bit clock and of the heartbeat, counted in system cycles
   sequence s_clk_half(logic lvl);
      (time_link_bit_clock == lvl) [*8] ##1 (time_link_bit_clock == lvl) [*2];
   endsequence
   sequence s_hb_bit;
      time_link_heartbeat [*8] ##1 time_link_heartbeat [*8] ##1 time_link_heartbeat [*4];
   endsequence
   property p_clk_high; armed && $rose(time_link_bit_clock) |-> s_clk_half(1'b1) ##1 !time_link_bit_clock; endproperty
   property p_clk_low; armed && $fell(time_link_bit_clock) |-> s_clk_half(1'b0) ##1 time_link_bit_clock; endproperty
   property p_value_step;
      armed && $changed(time_link_serial_value) |-> $past(time_link_bit_clock) && !$past(time_link_bit_clock, 2);
   endproperty
   property p_hb_step; $rose(time_link_heartbeat) |-> $past(time_link_bit_clock) && !$past(time_link_bit_clock, 2); endproperty
   property p_hb_width; $rose(time_link_heartbeat) |-> s_hb_bit ##1 !time_link_heartbeat; endproperty
   property p_hb_period; armed && $rose(time_link_heartbeat) |-> gap == FRAME * 20; endproperty
   property p_no_fight; !(dev_bit_clock_oe && peer_bit_clock_oe); endproperty
   property p_spare_value; !spare_serial_value_oe; endproperty
   a_clk_high: assert property (p_clk_high)
      else $error("bit clock high phase is not ten cycles");
   a_clk_low: assert property (p_clk_low)
      else $error("bit clock low phase is not ten cycles");
   a_value_step: assert property (p_value_step)
      else $error("value changed away from a bit clock rise");
   a_hb_step: assert property (p_hb_step)
      else $error("heartbeat rose away from a bit clock rise");
   a_hb_width: assert property (p_hb_width)
      else $error("heartbeat not one bit period wide");
   a_hb_period: assert property (p_hb_period)
      else $error("heartbeat spacing differs from the frame length");
   a_no_fight: assert property (p_no_fight)
      else $error("both ends drive the bit clock");
   a_spare_value: assert property (p_spare_value)
      else $error("spare value pin driven");
endmodule : time_link_checker

/* File: verification/testbench.sv */
// Self-checking bench joining the device end and the peer end.
// Assumes a short frame of 40 bit periods and both ends on one clock.
`timescale 1ns/1ps
module testbench;
   localparam int FRAME = 40;
   localparam int FR_CYC = FRAME * 20;
   logic I_CLK = 1'b0;
   logic I_SYS_RST = 1'b1;
   time_link_pkg::link_mode_t mode = time_link_pkg::MODE_SERIAL;
   logic dev_tx = 1'b1;
   logic peer_pll_en = 1'b0;
   logic [1:0] clk_en = 2'b00, hb_en = 2'b00, pll_en = 2'b00, raw = 2'b00;
   logic [1:0] tx_valid = 2'b00, rx_ready = 2'b11;
   logic [31:0] tx_time [2] = '{32'h0, 32'h0};
   logic [31:0] words [5] = '{32'h8000_0001, 32'h1234_5678, 32'hffff_ffff, 32'h0000_0001, 32'ha5c3_3c5a};
   wire logic [1:0] tx_ready, rx_valid, drop, hb_seen, p_lock;
   wire logic [31:0] rx_time [2];
   wire logic ref_clk;
   int n_fail = 0, n_compared = 0, n_ref = 0, n_spr = 0, n_drop = 0, n_hb = 0;
   logic ref_q = 1'b0, spr_q = 1'b0;
   always #2.5 I_CLK = ~I_CLK;
   // =====================================================================
   // Ends, pins and checker; in the per-end arrays index 0 is the device, 1 the peer
   // =====================================================================
   time_link_if link ();
   time_link_device #(.FRAME(FRAME)) time_link_device_i (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .link(link),
      .I_LINK_MODE(mode), .I_TRANSMITTER(dev_tx), .I_PACKET_CLK_OUT_EN(clk_en), .I_PACKET_HB_OUT_EN(hb_en),
      .I_STAMP_PLL_ENABLE(pll_en[1]), .I_SYNC_PLL_ENABLE(pll_en[0]), .I_STAMP_PLL_LOCK_RAW(raw[1]),
      .I_SYNC_PLL_LOCK_RAW(raw[0]), .O_PLL_REFERENCE_CLOCK(ref_clk), .I_TX_TIME(tx_time[0]),
      .I_TX_VALID(tx_valid[0]), .O_TX_READY(tx_ready[0]), .O_RX_TIME(rx_time[0]), .O_RX_VALID(rx_valid[0]),
      .I_RX_READY(rx_ready[0]), .O_RX_DROPPED(drop[0]), .O_HEARTBEAT_SEEN(hb_seen));
   time_link_peer #(.FRAME(FRAME)) time_link_peer_i (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .link(link),
      .I_TRANSMITTER(!dev_tx), .I_PLL_ENABLED(peer_pll_en), .I_TX_TIME(tx_time[1]), .I_TX_VALID(tx_valid[1]),
      .O_TX_READY(tx_ready[1]), .O_RX_TIME(rx_time[1]), .O_RX_VALID(rx_valid[1]), .I_RX_READY(rx_ready[1]),
      .O_RX_DROPPED(drop[1]), .O_STAMP_PLL_LOCKED(p_lock[1]), .O_SYNC_PLL_LOCKED(p_lock[0]));
   time_link_checker #(.FRAME(FRAME)) time_link_checker_i (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
      .dev_bit_clock_oe(link.dev_bit_clock_oe), .peer_bit_clock_oe(link.peer_bit_clock_oe),
      .spare_serial_value_oe(link.spare_serial_value_oe), .time_link_bit_clock(link.time_link_bit_clock),
      .time_link_heartbeat(link.time_link_heartbeat), .time_link_serial_value(link.time_link_serial_value));
   // Edge and pulse counters; rates are judged from counts, not from timestamps
   always @(posedge I_CLK) begin
      ref_q <= ref_clk;
      spr_q <= link.spare_bit_clock;
      n_ref <= n_ref + int'(ref_clk & !ref_q);
      n_spr <= n_spr + int'(link.spare_bit_clock & !spr_q);
      n_drop <= n_drop + int'(drop[1]);
      n_hb <= n_hb + int'(hb_seen[0]);
   end
   // =====================================================================
   // Tasks
   // =====================================================================
   function automatic logic [5:0] oes();
      return {link.dev_bit_clock_oe, link.dev_heartbeat_oe, link.dev_value_oe,
              link.spare_bit_clock_oe, link.spare_heartbeat_oe, link.spare_serial_value_oe};
   endfunction : oes
   task automatic close_out();
      if (n_fail == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wait_for(input logic cond);
      if (!cond) begin
         n_fail++;
         $display("Error at %0t: wait ran out", $time);
         close_out();
      end
   endtask : wait_for
   // Valid stays up between words so back-to-back sends never toggle it twice
   task automatic send(input int e, input logic [31:0] w);
      tx_time[e] = w;
      tx_valid[e] = 1'b1;
      for (int k = 0; k < 2000 && tx_ready[e] !== 1'b1; k++) @(negedge I_CLK);
      wait_for(tx_ready[e] === 1'b1);
      @(negedge I_CLK);
   endtask : send
   // Skips words of zero, which an idle transmitter repeats after reset
   task automatic recv(input int e, output logic [31:0] w);
      w = 32'h0;
      for (int n = 0; n < 4 && w === 32'h0; n++) begin
         for (int k = 0; k < 3 * FR_CYC && rx_valid[e] !== 1'b1; k++) @(negedge I_CLK);
         wait_for(rx_valid[e] === 1'b1);
         w = rx_time[e];
         @(negedge I_CLK);
      end
   endtask : recv
   task automatic do_reset(input int n);
      I_SYS_RST = 1'b1;
      repeat (n) @(negedge I_CLK);
      I_SYS_RST = 1'b0;
      repeat (FR_CYC) @(negedge I_CLK);
   endtask : do_reset
   // =====================================================================
   // Scenarios
   // =====================================================================
   initial begin
      logic [31:0] got;
      int a;
      @(negedge I_CLK);
      do_reset(6);
      for (int k = 0; k < 5; k++) send(0, words[k]);
      check(32'(tx_ready[0]), 32'h0);
      tx_valid[0] = 1'b0;
      check(32'(oes()), 32'h38);
      for (int k = 0; k < 6; k++) begin
         recv(1, got);
         check(got, words[k < 5 ? k : 4]);
      end
      rx_ready[1] = 1'b0;
      a = n_drop;
      repeat (3 * FR_CYC) @(negedge I_CLK);
      check(32'(n_drop > a), 32'h1);
      rx_ready[1] = 1'b1;
      for (int k = 0; k < 8; k++) begin
         raw = 2'(k);
         pll_en = 2'(k >> 1);
         peer_pll_en = k[0];
         repeat (8) @(negedge I_CLK);
         check(32'({link.stamp_pll_locked, link.sync_pll_locked}), 32'(pll_en & raw));
         check(32'(p_lock), 32'(pll_en & raw & {2{peer_pll_en}}));
      end
      a = n_ref;
      repeat (200) @(negedge I_CLK);
      check(32'(n_ref - a), 32'd25);
      dev_tx = 1'b0;
      do_reset(80);
      check(32'(oes()), 32'h0);
      send(1, words[1]);
      send(1, words[2]);
      tx_valid[1] = 1'b0;
      recv(0, got);
      check(got, words[1]);
      recv(0, got);
      check(got, words[2]);
      mode = time_link_pkg::MODE_PACKET;
      clk_en = 2'b10;
      hb_en = 2'b10;
      do_reset(80);
      a = n_spr;
      got = 32'(n_hb);
      repeat (1000) @(negedge I_CLK);
      check(32'(n_spr - a), 32'd50);
      check(32'(n_hb > int'(got)), 32'h1);
      check(32'(oes()), 32'h06);
      close_out();
   end
endmodule : testbench
